/* adc_out_pkg.sv */
// Purpose: constants for the converter output path and serial port
// Assumes: one core clock, inputs synchronous except the serial pins and the clock pin sources
// Notes: the decimation ratio is a power of two picked by a 3-bit code
package adc_out_pkg;
  // --------------------------------------------------------------------
  // numbers
  // --------------------------------------------------------------------
  localparam int WORD_BITS = 24;
  localparam int STATUS_BITS = 24;
  localparam logic [STATUS_BITS-1:0] STATUS_WORD = 24'hc00000;
  localparam logic [WORD_BITS-1:0] FULL_POS = 24'h7fffff;
  localparam logic [WORD_BITS-1:0] FULL_NEG = 24'h800000;
  localparam int ACC_BITS = 38;
  localparam int DEC_BITS = 12;
  localparam logic [3:0] BASE_LOG2_RATIO = 4'h6;
  localparam logic [2:0] MAX_RATE_CODE = 3'h6;
  localparam logic [1:0] SETTLE_WORDS = 2'h3;
  localparam int RX_BITS = 8;
  localparam logic REF_BUF_RESET = 1'b0;
  localparam int CORE_PERIOD_NS = 25;

  typedef enum logic [1:0] {
    CONV_HALT = 2'b00,
    CONV_SETTLE = 2'b01,
    CONV_RUN = 2'b10
  } conv_state_t;
endpackage : adc_out_pkg

/* adc_decimation_spi_output.sv */
// Purpose: sinc3 decimation, clipping, clock pin, reference bit, serial readout
// Assumes: serial pins asynchronous, clock pin sources free-running, everything else synchronous to CORE_CLK
// Notes: readout frame is a status word then one word per channel
`timescale 1ns/1ps
module adc_decimation_spi_output
  import adc_out_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // conversion control
  input wire logic START,
  input wire logic [2:0] OUTPUT_RATE_SELECT,
  input wire logic [CHANNELS-1:0] MOD_BITS,
  // clock pin
  input wire logic CLOCK_SOURCE_SELECT_PIN,
  input wire logic CLOCK_OUTPUT_ENABLE,
  input wire logic INT_OSC_CLK,
  input wire logic CLK_PIN_I,
  output logic CLK_PIN_O,
  output logic CLK_PIN_OE_N,
  output logic MASTER_CLOCK_OUT,
  // reference configuration
  input wire logic REFERENCE_WRITE,
  input wire logic REFERENCE_BUFFER_POWER_BIT,
  output logic REF_BUFFER_ON,
  output logic EXTERNAL_REF_MODE,
  // serial port
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic DIN,
  output logic DOUT_O,
  output logic DOUT_OE_N,
  output logic [RX_BITS-1:0] RX_BYTE,
  output logic RX_BYTE_VALID,
  // data ready
  output logic RESULT_AVAILABLE_N
);

  localparam int FRAME_BITS = STATUS_BITS + WORD_BITS * CHANNELS;
  localparam int EXT_BITS = ACC_BITS + WORD_BITS - 1;

  generate
    if (CHANNELS < 1 || CHANNELS > 8) begin : bad_channels
      $error("CHANNELS must be 1 to 8");
    end
  endgenerate

  // --------------------------------------------------------------------
  // clock pin and reference
  // --------------------------------------------------------------------
  // clock paths stay combinational: a 40 MHz clock cannot be retimed here
  assign MASTER_CLOCK_OUT = CLOCK_SOURCE_SELECT_PIN ? INT_OSC_CLK : CLK_PIN_I;
  assign CLK_PIN_O = INT_OSC_CLK;
  assign CLK_PIN_OE_N = ~(CLOCK_SOURCE_SELECT_PIN & CLOCK_OUTPUT_ENABLE);

  logic ref_buf;
  logic next_ref_buf;
  always_comb begin
    next_ref_buf = ref_buf;
    if (REFERENCE_WRITE) begin
      next_ref_buf = REFERENCE_BUFFER_POWER_BIT;
    end
  end
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ref_buf <= REF_BUF_RESET;
    end else begin
      ref_buf <= next_ref_buf;
    end
  end
  assign REF_BUFFER_ON = ref_buf;
  assign EXTERNAL_REF_MODE = ~ref_buf;

  // --------------------------------------------------------------------
  // conversion control
  // --------------------------------------------------------------------
  conv_state_t state, next_state;
  logic mod_phase, next_mod_phase;
  logic [DEC_BITS-1:0] dec_cnt, next_dec_cnt;
  logic [1:0] discard, next_discard;
  logic [2:0] rate, next_rate;
  logic start_d, next_start_d;
  logic publish, next_publish;
  logic flt_clear;
  logic mod_tick;
  logic word_tick;
  logic [3:0] log2_ratio;
  logic [DEC_BITS-1:0] ratio_m1;
  logic [5:0] shift_amt;
  logic [2:0] rate_in;

  assign rate_in = (OUTPUT_RATE_SELECT > MAX_RATE_CODE) ? MAX_RATE_CODE : OUTPUT_RATE_SELECT;
  assign log2_ratio = BASE_LOG2_RATIO + {1'b0, rate};
  assign ratio_m1 = DEC_BITS'((13'h1 << log2_ratio) - 13'h1);
  assign shift_amt = 6'(3 * log2_ratio);
  assign mod_tick = mod_phase;
  assign word_tick = mod_tick && (dec_cnt == ratio_m1);

  always_comb begin
    next_state = state;
    next_discard = discard;
    next_rate = rate_in;
    next_start_d = START;
    next_publish = 1'b0;
    next_mod_phase = ~mod_phase;
    next_dec_cnt = dec_cnt;
    flt_clear = 1'b0;
    if (mod_tick) begin
      next_dec_cnt = word_tick ? '0 : dec_cnt + 1'b1;
    end
    if (!START) begin
      next_state = CONV_HALT;
      flt_clear = 1'b1;
    end else if (!start_d || rate_in != rate) begin
      // rate change restarts the filter so no mixed-ratio word escapes
      next_state = CONV_SETTLE;
      next_discard = '0;
      flt_clear = 1'b1;
    end
    if (flt_clear) begin
      next_dec_cnt = '0;
      next_mod_phase = 1'b0;
    end else if (word_tick) begin
      case (state)
        CONV_SETTLE: begin
          next_discard = discard + 1'b1;
          if (discard == SETTLE_WORDS - 2'h1) begin
            next_state = CONV_RUN;
          end
        end
        CONV_RUN: begin
          next_publish = 1'b1;
        end
        default: begin
          next_state = CONV_HALT;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= CONV_HALT;
      {discard, rate, dec_cnt} <= '0;
      {start_d, publish, mod_phase} <= '0;
    end else begin
      state <= next_state;
      discard <= next_discard;
      rate <= next_rate;
      start_d <= next_start_d;
      publish <= next_publish;
      mod_phase <= next_mod_phase;
      dec_cnt <= next_dec_cnt;
    end
  end

  // --------------------------------------------------------------------
  // sinc3 filter per channel
  // --------------------------------------------------------------------
  logic [FRAME_BITS-1:0] new_frame;
  assign new_frame[FRAME_BITS-1 -: STATUS_BITS] = STATUS_WORD;

  genvar c;
  generate
    for (c = 0; c < CHANNELS; c++) begin : chan
      logic signed [ACC_BITS-1:0] i1, i2, i3, z1, z2, z3;
      logic signed [ACC_BITS-1:0] next_i1, next_i2, next_i3, next_z1, next_z2, next_z3;
      logic signed [ACC_BITS-1:0] x, d1, d2, d3;
      logic signed [EXT_BITS-1:0] scaled;
      logic [WORD_BITS-1:0] word;
      assign x = MOD_BITS[c] ? ACC_BITS'(1) : -ACC_BITS'(1);
      assign d1 = i3 - z1;
      assign d2 = d1 - z2;
      assign d3 = d2 - z3;
      // full scale is ratio cubed; bring it to 2^23 before clipping
      assign scaled = $signed({d3, {(WORD_BITS-1){1'b0}}}) >>> shift_amt;
      always_comb begin
        if (&scaled[EXT_BITS-1:WORD_BITS-1] || ~|scaled[EXT_BITS-1:WORD_BITS-1]) begin
          word = scaled[WORD_BITS-1:0];
        end else begin
          word = scaled[EXT_BITS-1] ? FULL_NEG : FULL_POS;
        end
      end
      assign new_frame[FRAME_BITS-1-STATUS_BITS-WORD_BITS*c -: WORD_BITS] = word;
      always_comb begin
        {next_i1, next_i2, next_i3, next_z1, next_z2, next_z3} = {i1, i2, i3, z1, z2, z3};
        if (flt_clear) begin
          {next_i1, next_i2, next_i3, next_z1, next_z2, next_z3} = '0;
        end else begin
          if (mod_tick) begin
            next_i1 = i1 + x;
            next_i2 = i2 + i1;
            next_i3 = i3 + i2;
          end
          if (word_tick) begin
            next_z1 = i3;
            next_z2 = d1;
            next_z3 = d2;
          end
        end
      end
      always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
          {i1, i2, i3, z1, z2, z3} <= '0;
        end else begin
          {i1, i2, i3, z1, z2, z3} <= {next_i1, next_i2, next_i3, next_z1, next_z2, next_z3};
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // serial port
  // --------------------------------------------------------------------
  logic [2:0] sync1, sync2, sync3;
  logic cs_s, sclk_rise, sclk_fall, din_s;
  logic [FRAME_BITS-1:0] latest, next_latest, frame, next_frame;
  logic ready_n, next_ready_n;
  logic dout, next_dout;
  logic [RX_BITS-1:0] rx, next_rx, rx_byte, next_rx_byte;
  logic [2:0] rx_cnt, next_rx_cnt;
  logic rx_valid, next_rx_valid;

  // bit 0 chip select, 1 serial clock, 2 data-in
  assign cs_s = sync2[0];
  assign sclk_rise = ~cs_s & sync2[1] & ~sync3[1];
  assign sclk_fall = ~cs_s & ~sync2[1] & sync3[1];
  assign din_s = sync2[2];

  always_comb begin
    next_latest = next_publish ? new_frame : latest; // comb taps only hold the word on the tick itself
    next_frame = frame;
    next_dout = dout;
    next_rx = rx;
    next_rx_cnt = rx_cnt;
    next_rx_byte = rx_byte;
    next_rx_valid = 1'b0;
    next_ready_n = ready_n;
    if (sclk_fall || (START && !start_d)) begin
      next_ready_n = 1'b1;
    end
    if (publish) begin
      next_ready_n = 1'b0;
    end
    if (cs_s) begin
      // idle port: reload from newest result, drop partial input
      next_frame = latest;
      next_rx = '0;
      next_rx_cnt = '0;
      next_dout = 1'b0;
    end else begin
      if (sclk_rise) begin
        // rotate so extra clocks repeat the frame from its head
        next_dout = frame[FRAME_BITS-1];
        next_frame = {frame[FRAME_BITS-2:0], frame[FRAME_BITS-1]};
      end
      if (sclk_fall) begin
        next_rx = {rx[RX_BITS-2:0], din_s};
        next_rx_cnt = rx_cnt + 1'b1;
        if (rx_cnt == 3'h7) begin
          next_rx_byte = {rx[RX_BITS-2:0], din_s};
          next_rx_valid = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      {sync1, sync2, sync3} <= {3'h1, 3'h1, 3'h1};
      {latest, frame} <= '0;
      dout <= 1'b0;
      {rx, rx_cnt, rx_byte} <= '0;
      rx_valid <= 1'b0;
      ready_n <= 1'b1;
    end else begin
      sync1 <= {DIN, SCLK, CS_N};
      sync2 <= sync1;
      sync3 <= sync2;
      latest <= next_latest;
      frame <= next_frame;
      dout <= next_dout;
      rx <= next_rx;
      rx_cnt <= next_rx_cnt;
      rx_byte <= next_rx_byte;
      rx_valid <= next_rx_valid;
      ready_n <= next_ready_n;
    end
  end

  assign DOUT_O = dout;
  assign DOUT_OE_N = cs_s;
  assign RX_BYTE = rx_byte;
  assign RX_BYTE_VALID = rx_valid;
  assign RESULT_AVAILABLE_N = ready_n;
endmodule : adc_decimation_spi_output

/* adc_out_properties.sv */
// Purpose: port checks for the converter output block
// Assumes: one CORE_CLK domain, RST_B async low
// Notes: settling is checked as a floor only
`timescale 1ns/1ps
module adc_out_checker
  import adc_out_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // conversion
  input wire logic START,
  input wire logic [2:0] OUTPUT_RATE_SELECT,
  input wire logic RESULT_AVAILABLE_N,
  // clock pin
  input wire logic CLOCK_SOURCE_SELECT_PIN,
  input wire logic CLOCK_OUTPUT_ENABLE,
  input wire logic INT_OSC_CLK,
  input wire logic CLK_PIN_I,
  input wire logic CLK_PIN_OE_N,
  input wire logic MASTER_CLOCK_OUT,
  // reference
  input wire logic REFERENCE_WRITE,
  input wire logic REFERENCE_BUFFER_POWER_BIT,
  input wire logic REF_BUFFER_ON,
  input wire logic EXTERNAL_REF_MODE,
  // serial
  input wire logic CS_N,
  input wire logic DOUT_OE_N,
  input wire logic RX_BYTE_VALID
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  // --------------------------------------------------------------
  // cycles since settling began
  // --------------------------------------------------------------
  logic [15:0] since;
  logic [15:0] next_since;
  logic start_q;
  logic [2:0] code;
  logic [2:0] rate_q;
  assign code = (OUTPUT_RATE_SELECT > MAX_RATE_CODE) ? MAX_RATE_CODE : OUTPUT_RATE_SELECT;
  always_comb begin
    next_since = (since == 16'hffff) ? since : since + 16'h1;
    if (START && (!start_q || rate_q != code)) begin
      next_since = 16'h0;
    end
  end
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      since <= 16'hffff;
      start_q <= 1'b0;
      rate_q <= 3'h0;
    end else begin
      since <= next_since;
      start_q <= START;
      rate_q <= code;
    end
  end
  sequence cs_idle;
    CS_N [*4];
  endsequence
  AST_CLK_PIN_DRIVE: assert property (CLK_PIN_OE_N == !(CLOCK_SOURCE_SELECT_PIN && CLOCK_OUTPUT_ENABLE))
    else $error("clock pin drive wrong");
  AST_MASTER_CLOCK: assert property (MASTER_CLOCK_OUT == (CLOCK_SOURCE_SELECT_PIN ? INT_OSC_CLK : CLK_PIN_I))
    else $error("master clock source wrong");
  AST_EXT_REF: assert property (EXTERNAL_REF_MODE == !REF_BUFFER_ON)
    else $error("reference mode mismatch");
  AST_REF_LOAD: assert property (REFERENCE_WRITE |=> REF_BUFFER_ON == $past(REFERENCE_BUFFER_POWER_BIT))
    else $error("buffer bit not loaded");
  AST_REF_HOLD: assert property (!REFERENCE_WRITE |=> $stable(REF_BUFFER_ON))
    else $error("buffer bit changed without write");
  AST_DOUT_FLOAT: assert property (cs_idle |-> DOUT_OE_N)
    else $error("data out driven while deselected");
  AST_DOUT_DRIVE: assert property ($fell(CS_N) |-> ##[1:3] !DOUT_OE_N)
    else $error("data out not driven after select");
  AST_START_CLEAR: assert property ($rose(START) |=> RESULT_AVAILABLE_N [*8])
    else $error("ready low right after start");
  AST_SETTLE_FLOOR: assert property ($fell(RESULT_AVAILABLE_N) |-> since >= (16'h200 << code) - 16'h8)
    else $error("result before settling");
  AST_RX_PULSE: assert property (RX_BYTE_VALID |=> !RX_BYTE_VALID)
    else $error("byte valid longer than one cycle");
endmodule : adc_out_checker
bind adc_decimation_spi_output adc_out_checker chk_u (.CORE_CLK, .RST_B, .START, .OUTPUT_RATE_SELECT,
  .RESULT_AVAILABLE_N, .CLOCK_SOURCE_SELECT_PIN, .CLOCK_OUTPUT_ENABLE, .INT_OSC_CLK, .CLK_PIN_I,
  .CLK_PIN_OE_N, .MASTER_CLOCK_OUT, .REFERENCE_WRITE, .REFERENCE_BUFFER_POWER_BIT, .REF_BUFFER_ON,
  .EXTERNAL_REF_MODE, .CS_N, .DOUT_OE_N, .RX_BYTE_VALID);

/* spi_host_model.sv */
// Purpose: host acting as serial master
// Assumes: SCLK half period of four core clocks
// Notes: a floating data line reads back inverted
`timescale 1ns/1ps
module spi_host_model (
  // pacing clock
  input wire logic core_clk,
  // serial pins
  output logic cs_n,
  output logic sclk,
  output logic din,
  input wire logic dout_o,
  input wire logic dout_oe_n
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  task automatic frame(input logic [47:0] tx, output logic [47:0] rx);
    @(posedge core_clk);
    cs_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    for (int i = 47; i >= 0; i--) begin // whole bytes, fast enough
      sclk <= 1'b1;
      din <= tx[i];
      repeat (4) @(posedge core_clk);
      rx[i] = dout_oe_n ? ~dout_o : dout_o;
      sclk <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    repeat (6) @(posedge core_clk);
    cs_n <= 1'b1;
    din <= ~din;
    repeat (4) @(posedge core_clk);
  endtask : frame
endmodule : spi_host_model

/* adc_decimation_spi_output_tb_top.sv */
// Purpose: self-checking bench for the converter output block
// Assumes: rate code 1 so a result follows about 1024 cycles after start
// Notes: clock pin sources run free, unrelated to CORE_CLK
`timescale 1ns/1ps
module adc_decimation_spi_output_tb_top;
  import adc_out_pkg::*;
  logic CORE_CLK = 1'b0;
  logic RST_B = 1'b0;
  logic START = 1'b0;
  logic [2:0] OUTPUT_RATE_SELECT = 3'h1;
  logic [7:0] MOD_BITS = 8'h00;
  logic CLOCK_SOURCE_SELECT_PIN = 1'b0;
  logic CLOCK_OUTPUT_ENABLE = 1'b0;
  logic INT_OSC_CLK = 1'b0;
  logic CLK_PIN_I = 1'b0;
  logic REFERENCE_WRITE = 1'b0;
  logic REFERENCE_BUFFER_POWER_BIT = 1'b0;
  logic CS_N, SCLK, DIN, DOUT_O, DOUT_OE_N, RX_BYTE_VALID, RESULT_AVAILABLE_N;
  logic CLK_PIN_O, CLK_PIN_OE_N, MASTER_CLOCK_OUT, REF_BUFFER_ON, EXTERNAL_REF_MODE;
  logic [7:0] RX_BYTE;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_rx_valid = 0;
  always #12.5 CORE_CLK = ~CORE_CLK;
  always #7 INT_OSC_CLK = ~INT_OSC_CLK;
  always #11 CLK_PIN_I = ~CLK_PIN_I;
  adc_decimation_spi_output dut_u (.CORE_CLK, .RST_B, .START, .OUTPUT_RATE_SELECT, .MOD_BITS,
    .CLOCK_SOURCE_SELECT_PIN, .CLOCK_OUTPUT_ENABLE, .INT_OSC_CLK, .CLK_PIN_I, .CLK_PIN_O,
    .CLK_PIN_OE_N, .MASTER_CLOCK_OUT, .REFERENCE_WRITE, .REFERENCE_BUFFER_POWER_BIT,
    .REF_BUFFER_ON, .EXTERNAL_REF_MODE, .CS_N, .SCLK, .DIN, .DOUT_O, .DOUT_OE_N, .RX_BYTE,
    .RX_BYTE_VALID, .RESULT_AVAILABLE_N);
  spi_host_model host_u (.core_clk(CORE_CLK), .cs_n(CS_N), .sclk(SCLK), .din(DIN),
    .dout_o(DOUT_O), .dout_oe_n(DOUT_OE_N));
  // --------------------------------------------------------------
  // checking and closing
  // --------------------------------------------------------------
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  // ceiling well above the ~2900 cycles the run needs
  always @(posedge CORE_CLK) begin
    cycles++;
    if (RX_BYTE_VALID === 1'b1) n_rx_valid++;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic t_reset();
    #1;
    check("ref_on", 24'(REF_BUFFER_ON), 24'h0);
    check("ready_n", 24'(RESULT_AVAILABLE_N), 24'h1);
    check("dout_oe_n", 24'(DOUT_OE_N), 24'h1);
  endtask : t_reset
  task automatic t_clock_pin();
    for (int k = 0; k < 4; k++) begin
      @(posedge CORE_CLK);
      CLOCK_SOURCE_SELECT_PIN <= k[1];
      CLOCK_OUTPUT_ENABLE <= k[0];
      #1;
      check("clk_oe_n", 24'(CLK_PIN_OE_N), 24'(k != 3));
      check("mclk", 24'(MASTER_CLOCK_OUT), 24'(k[1] ? INT_OSC_CLK : CLK_PIN_I));
      check("clk_o", 24'(CLK_PIN_O), 24'(INT_OSC_CLK));
    end
  endtask : t_clock_pin
  task automatic t_reference(input logic on);
    @(posedge CORE_CLK);
    REFERENCE_BUFFER_POWER_BIT <= on;
    REFERENCE_WRITE <= 1'b1;
    @(posedge CORE_CLK);
    REFERENCE_WRITE <= 1'b0;
    @(posedge CORE_CLK);
    #1;
    check("ref_on", 24'(REF_BUFFER_ON), 24'(on));
    check("ext_ref", 24'(EXTERNAL_REF_MODE), 24'(!on));
  endtask : t_reference
  // deselected while waiting, so ready must not depend on select
  task automatic t_convert(input logic [7:0] mod, input logic [23:0] exp);
    int cnt;
    int rx_before;
    logic [47:0] rx;
    cnt = 0;
    @(posedge CORE_CLK);
    MOD_BITS <= mod;
    START <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    START <= 1'b1;
    @(posedge CORE_CLK);
    #1;
    while (RESULT_AVAILABLE_N !== 1'b0 && cnt < 2000) begin
      @(posedge CORE_CLK);
      #1;
      cnt++;
    end
    check("settle", 24'(cnt >= 1016 && cnt <= 1036), 24'h1);
    rx_before = n_rx_valid;
    host_u.frame(48'h5a3c_0000_00c3, rx);
    check("rx_valid_count", 24'(n_rx_valid - rx_before), 24'h6);
    check("status", rx[47:24], STATUS_WORD);
    check("chan0", rx[23:0], exp);
    check("rx_byte", 24'(RX_BYTE), 24'hc3);
    check("ready_n", 24'(RESULT_AVAILABLE_N), 24'h1);
    check("dout_oe_n", 24'(DOUT_OE_N), 24'h1);
    check("dout_idle", 24'(DOUT_O), 24'h0);
  endtask : t_convert
  initial begin
    repeat (10) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    t_reset();
    t_clock_pin();
    t_reference(1'b1);
    t_reference(1'b0);
    t_convert(8'hff, FULL_POS);
    t_convert(8'h00, FULL_NEG);
    summarize();
  end
endmodule : adc_decimation_spi_output_tb_top
